//--- rtl/vlu_top.sv
// vector logical unit: issue, timing, element datapath and result stream
`timescale 1ns/100ps
`include "vlu_consts.svh"
module vlu_top #(
   parameter int ELEM_W = `VLU_ELEM_W,
   parameter int VL_MAX = `VLU_VL_MAX,
   parameter int FIFO_DEPTH = `VLU_FIFO_DEPTH
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic issue_valid,
   input wire logic [6:0] issue_op,
   input wire logic [2:0] issue_dst,
   input wire logic [2:0] issue_src1,
   input wire logic [2:0] issue_src2,
   input wire logic [ELEM_W-1:0] source_scalar_reg,
   input wire logic [6:0] vec_length,
   input wire logic regs_free,
   output logic issue_ready,
   output logic next_issue_pulse,
   output logic src_release_pulse,
   output logic dest_ready_pulse,
   output logic unit_free_pulse,
   output logic [2:0] dest_vector_reg,
   output logic [2:0] first_source_vector_reg,
   output logic [2:0] second_source_vector_reg,
   input wire logic elem_valid,
   input wire logic [ELEM_W-1:0] first_source_elem,
   input wire logic [ELEM_W-1:0] second_source_elem,
   output logic elem_ready,
   output logic res_valid,
   output logic [ELEM_W-1:0] res_data,
   output logic [5:0] res_index,
   input wire logic res_ready
);
   localparam int CW = $clog2(FIFO_DEPTH) + 1;
   localparam int FW = ELEM_W + 6;

   initial begin
      if (ELEM_W < 1 || VL_MAX < 1 || VL_MAX > 64 || FIFO_DEPTH < 2) begin
         $error("vlu_top: unsupported parameter values");
      end
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // phase figure to cycles after issue, minus the pulse register delay
   function automatic logic [7:0] tgt_cyc(input logic [7:0] phase);
      logic [8:0] cyc;
      cyc = ({1'b0, phase} + `VLU_PH_PER_CLK - 9'h001) >> 1;
      return cyc[7:0] - 8'h01;
   endfunction

   // one element; every bit stands alone, no carries between elements
   function automatic logic [ELEM_W-1:0] apply_fn(input vlu_pkg::vlu_fn_t fn,
         input logic [ELEM_W-1:0] a, input logic [ELEM_W-1:0] b);
      logic [ELEM_W-1:0] r;
      r = '0;
      unique case (fn)
         vlu_pkg::VLU_FN_AND: r = a & b;
         vlu_pkg::VLU_FN_XOR: r = a ^ b;
         vlu_pkg::VLU_FN_OR: r = a | b;
         vlu_pkg::VLU_FN_NONE: r = '0;
      endcase
      return r;
   endfunction

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   vlu_pkg::vlu_fn_t dec_fn;
   logic dec_scalar;

   // reserved and foreign codes decode to no function
   always_comb begin
      dec_fn = vlu_pkg::VLU_FN_NONE;
      dec_scalar = 1'b0;
      case (issue_op)
         `VLU_OP_AND_SV: begin
            dec_fn = vlu_pkg::VLU_FN_AND;
            dec_scalar = 1'b1;
         end
         `VLU_OP_AND_VV: dec_fn = vlu_pkg::VLU_FN_AND;
         `VLU_OP_XOR_SV: begin
            dec_fn = vlu_pkg::VLU_FN_XOR;
            dec_scalar = 1'b1;
         end
         `VLU_OP_XOR_VV: dec_fn = vlu_pkg::VLU_FN_XOR;
         `VLU_OP_OR_SV: begin
            dec_fn = vlu_pkg::VLU_FN_OR;
            dec_scalar = 1'b1;
         end
         `VLU_OP_OR_VV: dec_fn = vlu_pkg::VLU_FN_OR;
         default: dec_fn = vlu_pkg::VLU_FN_NONE;
      endcase
   end

   // ------------------------------------------------------------
   // issue and occupancy
   // ------------------------------------------------------------
   vlu_pkg::vlu_state_t state_r;
   vlu_pkg::vlu_fn_t fn_r;
   logic scalar_form_r;
   logic [ELEM_W-1:0] scalar_r;
   logic [6:0] vl_r;
   logic issue_take;
   logic start;
   logic unit_evt;
   logic [6:0] vl_ext;

   assign issue_take = issue_valid && issue_ready && regs_free;
   // zero length or no function: issues as a null, unit stays free
   assign start = issue_take && dec_fn != vlu_pkg::VLU_FN_NONE && vec_length != 7'h00;
   assign vl_ext = (vec_length > `VLU_VL_FLAT) ? vec_length - `VLU_VL_FLAT : 7'h00;

   // unit state and ready; ready is low for the whole stream
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= vlu_pkg::VLU_IDLE;
         issue_ready <= 1'b0;
      end else if (start) begin
         state_r <= vlu_pkg::VLU_RUN;
         issue_ready <= 1'b0;
      end else if (unit_evt || state_r == vlu_pkg::VLU_IDLE) begin
         state_r <= vlu_pkg::VLU_IDLE;
         issue_ready <= 1'b1;
      end
   end

   // operands held for the stream; scalar taken only at issue
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fn_r <= vlu_pkg::VLU_FN_NONE;
         scalar_form_r <= 1'b0;
         scalar_r <= '0;
         vl_r <= 7'h00;
         dest_vector_reg <= 3'h0;
         first_source_vector_reg <= 3'h0;
         second_source_vector_reg <= 3'h0;
      end else if (start) begin
         fn_r <= dec_fn;
         scalar_form_r <= dec_scalar;
         scalar_r <= source_scalar_reg;
         vl_r <= vec_length;
         dest_vector_reg <= issue_dst;
         first_source_vector_reg <= issue_src1;
         second_source_vector_reg <= issue_src2;
      end
   end

   // ------------------------------------------------------------
   // completion timing
   // ------------------------------------------------------------
   logic [7:0] cyc_r;
   logic [7:0] src_tgt_r;
   logic [7:0] dst_tgt_r;
   logic [7:0] unit_tgt_r;
   logic src_done_r;
   logic dst_pend_r;
   logic [7:0] dst_wait_r;
   logic dst_now;
   logic taken_all;
   logic out_all;
   logic run;

   assign run = (state_r == vlu_pkg::VLU_RUN);
   // the unit frees at its own time once all results are out and sources released; the destination may wait longer
   assign unit_evt = run && cyc_r >= unit_tgt_r && out_all && src_done_r;
   assign dst_now = unit_evt && cyc_r >= dst_tgt_r;

   // each extra element adds two phases, one clock
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cyc_r <= 8'h00;
         src_tgt_r <= 8'h00;
         dst_tgt_r <= 8'h00;
         unit_tgt_r <= 8'h00;
      end else if (start) begin
         cyc_r <= 8'h01;
         src_tgt_r <= tgt_cyc(`VLU_PH_SRC_FREE + {vl_ext, 1'b0});
         dst_tgt_r <= tgt_cyc(`VLU_PH_DST_FREE + {vec_length - 7'h01, 1'b0});
         unit_tgt_r <= tgt_cyc(`VLU_PH_UNIT_FREE + {vl_ext, 1'b0});
      end else if (run && cyc_r != 8'hFF) begin
         cyc_r <= cyc_r + 8'h01;
      end
   end

   // release and free pulses wait for the stream, next issue does not; destination release is timed on from unit free
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         next_issue_pulse <= 1'b0;
         src_release_pulse <= 1'b0;
         dest_ready_pulse <= 1'b0;
         unit_free_pulse <= 1'b0;
         src_done_r <= 1'b0;
         dst_pend_r <= 1'b0;
         dst_wait_r <= 8'h00;
      end else begin
         next_issue_pulse <= issue_take;
         src_release_pulse <= run && !src_done_r && cyc_r >= src_tgt_r && taken_all;
         dest_ready_pulse <= dst_now || (dst_pend_r && dst_wait_r == 8'h00);
         unit_free_pulse <= unit_evt;
         src_done_r <= !start && (src_done_r || (run && cyc_r >= src_tgt_r && taken_all));
         dst_pend_r <= unit_evt ? !dst_now : dst_pend_r && dst_wait_r != 8'h00;
         dst_wait_r <= unit_evt ? dst_tgt_r - cyc_r - 8'h01 : dst_wait_r - 8'h01;
      end
   end

   // ------------------------------------------------------------
   // element datapath
   // ------------------------------------------------------------
   logic [6:0] take_cnt_r;
   logic [6:0] out_cnt_r;
   logic take;
   logic [ELEM_W-1:0] op_a;
   logic [ELEM_W-1:0] push_data;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [FW-1:0] fifo_out_data;
   logic [CW-1:0] fifo_count;
   logic [7:0] take_next;
   logic [CW:0] fill_next;

   assign take = elem_valid && elem_ready && fifo_in_ready;
   assign taken_all = (take_cnt_r == vl_r);
   assign out_all = (out_cnt_r == vl_r);
   assign op_a = scalar_form_r ? scalar_r : first_source_elem;
   assign push_data = apply_fn(fn_r, op_a, second_source_elem);
   assign take_next = {1'b0, take_cnt_r} + {7'h00, take};
   assign fill_next = {1'b0, fifo_count} + {{CW{1'b0}}, take};

   // ready looks one element ahead, so it never overfills the buffer
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         elem_ready <= 1'b0;
         take_cnt_r <= 7'h00;
      end else if (start) begin
         elem_ready <= 1'b1;
         take_cnt_r <= 7'h00;
      end else begin
         elem_ready <= run && take_next < {1'b0, vl_r} &&
            fill_next < (CW+1)'(FIFO_DEPTH);
         take_cnt_r <= take_next[6:0];
      end
   end

   vlu_fifo #(
      .WIDTH(FW),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .in_valid(take),
      .in_ready(fifo_in_ready),
      .in_data({take_cnt_r[5:0], push_data}),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data),
      .count(fifo_count)
   );

   // ------------------------------------------------------------
   // result output stage
   // ------------------------------------------------------------
   assign fifo_out_ready = !res_valid || res_ready;

   // registered head so outputs come from flops
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         res_valid <= 1'b0;
         res_data <= '0;
         res_index <= 6'h00;
      end else if (fifo_out_ready) begin
         res_valid <= fifo_out_valid;
         if (fifo_out_valid) begin
            res_data <= fifo_out_data[ELEM_W-1:0];
            res_index <= fifo_out_data[FW-1:ELEM_W];
         end
      end
   end

   // delivered results
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         out_cnt_r <= 7'h00;
      end else if (start) begin
         out_cnt_r <= 7'h00;
      end else if (res_valid && res_ready) begin
         out_cnt_r <= out_cnt_r + 7'h01;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence s_null_issue;
      issue_take && dec_fn == vlu_pkg::VLU_FN_NONE;
   endsequence
   sequence s_next_pulse;
      ##1 next_issue_pulse && state_r == vlu_pkg::VLU_IDLE;
   endsequence
   property p_take_fn(f, sc, logic [ELEM_W-1:0] exp);
      @(posedge core_clk) disable iff (!rst_n)
      (take && fn_r == f && scalar_form_r == sc) |-> push_data == exp;
   endproperty

   chk_noop_next: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_null_issue |-> s_next_pulse) else $error("null issue not completed in phase 2");
   chk_and_sv: assert property (p_take_fn(vlu_pkg::VLU_FN_AND, 1'b1,
      scalar_r & second_source_elem)) else $error("scalar AND wrong");
   chk_and_vv: assert property (p_take_fn(vlu_pkg::VLU_FN_AND, 1'b0,
      first_source_elem & second_source_elem)) else $error("vector AND wrong");
   chk_xor_sv: assert property (p_take_fn(vlu_pkg::VLU_FN_XOR, 1'b1,
      scalar_r ^ second_source_elem)) else $error("scalar XOR wrong");
   chk_xor_vv: assert property (p_take_fn(vlu_pkg::VLU_FN_XOR, 1'b0,
      first_source_elem ^ second_source_elem)) else $error("vector XOR wrong");
   chk_or_sv: assert property (p_take_fn(vlu_pkg::VLU_FN_OR, 1'b1,
      scalar_r | second_source_elem)) else $error("scalar OR wrong");
   chk_or_vv: assert property (p_take_fn(vlu_pkg::VLU_FN_OR, 1'b0,
      first_source_elem | second_source_elem)) else $error("vector OR wrong");
   chk_elem_count: assert property (@(posedge core_clk) disable iff (!rst_n)
      unit_free_pulse |-> $past(take_cnt_r) == $past(vl_r)) else $error("element count wrong");
   chk_scalar_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      run && !start |=> $stable(scalar_r)) else $error("scalar changed mid-stream");
   chk_issue_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
      start |-> regs_free ##1 run && !issue_ready) else $error("issued while busy");
   chk_dst_time: assert property (@(posedge core_clk) disable iff (!rst_n)
      unit_free_pulse |-> ##[0:3] dest_ready_pulse) else $error("destination release late");
   chk_src_time: assert property (@(posedge core_clk) disable iff (!rst_n)
      start && vec_length == 7'h01 ##1 elem_valid [*8] |-> ##[1:3] src_release_pulse)
      else $error("source release not in phase 17");
   chk_result_order: assert property (@(posedge core_clk) disable iff (!rst_n)
      res_valid && res_ready |-> res_index == out_cnt_r[5:0]) else $error("result out of order");
endmodule

//--- rtl/vlu_consts.svh
// constants for the vector logical unit: opcodes, phase figures, sizes
//
// Behaviour
// - reserved opcodes 136/137 run as no-ops
// - scalar AND each second-source element
// - elementwise AND of two source vectors
// - scalar XOR each second-source element
// - elementwise XOR of two source vectors
// - scalar OR each second-source element
// - opcode 145 decodes as elementwise OR
// - 145 result: 64-bit OR of pair
// - element count equals vector length register
// - scalar captured once, held whole operation
// - elements independent, full 64-bit results
// - issue only when registers and unit free
// - next instruction to issue in phase 2
// - destination free phase 21 plus two/element
// - sources phase 17, unit phase 22, beyond four
// - two phases per clock period
`ifndef VLU_CONSTS_SVH
`define VLU_CONSTS_SVH

// ------------------------------------------------------------
// opcodes, top three octal digits
// ------------------------------------------------------------
`define VLU_OP_RSV_A 7'h5E
`define VLU_OP_RSV_B 7'h5F
`define VLU_OP_AND_SV 7'h60
`define VLU_OP_AND_VV 7'h61
`define VLU_OP_XOR_SV 7'h62
`define VLU_OP_XOR_VV 7'h63
`define VLU_OP_OR_SV 7'h64
`define VLU_OP_OR_VV 7'h65

// ------------------------------------------------------------
// timing in half-clock phases
// ------------------------------------------------------------
`define VLU_PH_PER_CLK 9'h002
`define VLU_PH_NEXT 8'h02
`define VLU_PH_SRC_FREE 8'h11
`define VLU_PH_DST_FREE 8'h15
`define VLU_PH_UNIT_FREE 8'h16
`define VLU_VL_FLAT 7'h04

// ------------------------------------------------------------
// sizes
// ------------------------------------------------------------
`define VLU_ELEM_W 64
`define VLU_VL_MAX 64
`define VLU_FIFO_DEPTH 8

`endif

//--- rtl/vlu_pkg.sv
// types shared by the vector logical unit
package vlu_pkg;
   // bitwise function selected by the opcode
   typedef enum logic [1:0] {
      VLU_FN_NONE,
      VLU_FN_AND,
      VLU_FN_XOR,
      VLU_FN_OR
   } vlu_fn_t;
   // unit occupancy
   typedef enum logic {
      VLU_IDLE,
      VLU_RUN
   } vlu_state_t;
endpackage

//--- rtl/vlu_fifo.sv
// result buffer between the logical datapath and the destination port
`timescale 1ns/100ps
module vlu_fifo #(
   parameter int WIDTH = 70,
   parameter int DEPTH = 8
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH):0] count
);
   localparam int AW = $clog2(DEPTH);

   // pointer wrap relies on a power-of-two depth
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
         $error("vlu_fifo: DEPTH must be a power of two >= 2");
      end
   end

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0] wr_ptr_r;
   logic [AW:0] rd_ptr_r;
   logic push;
   logic pop;

   // extra pointer bit tells full from empty
   assign count = wr_ptr_r - rd_ptr_r;
   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem_r[rd_ptr_r[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // pointers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
      end
   end

   // storage, no reset needed since empty slots are never read out
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem_r[wr_ptr_r[AW-1:0]] <= in_data;
      end
   end
endmodule

//--- tb/vlu_src_model.sv
// source register file and destination sink model for the vector logical unit
`timescale 1ns/100ps
module vlu_src_model (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic restart,
   input wire logic jitter,
   input wire logic hold_res,
   input wire logic [63:0] pa,
   input wire logic [63:0] pb,
   input wire logic elem_ready,
   output logic elem_valid,
   output logic [63:0] first_source_elem,
   output logic [63:0] second_source_elem,
   output logic res_ready,
   output logic [6:0] taken_cnt
);
   logic took;
   logic rs;
   initial begin
      elem_valid = 1'b0;
      first_source_elem = 64'h0;
      second_source_elem = 64'h0;
      res_ready = 1'b0;
      taken_cnt = 7'h00;
   end
   // ------------------------------------------------------------
   // element supply and result sink
   // ------------------------------------------------------------
   // element n sits at position n and is held until taken
   always @(posedge core_clk) begin
      took = elem_valid && elem_ready;
      rs = restart;
      #1;
      if (!rst_n || rs) begin
         taken_cnt = 7'h00;
         elem_valid = 1'b0;
      end else begin
         if (took) taken_cnt = taken_cnt + 7'h01;
         if (!elem_valid || took) elem_valid = taken_cnt < 7'h40 && (!jitter || $urandom_range(1, 0) == 1);
      end
      // released lines flip each cycle so a stale word never matches
      if (elem_valid) begin
         first_source_elem = pa ^ {8{1'b0, taken_cnt}};
         second_source_elem = pb + 64'(taken_cnt);
      end else begin
         first_source_elem = ~first_source_elem;
         second_source_elem = ~second_source_elem;
      end
      res_ready = rst_n && !hold_res && (!jitter || $urandom_range(3, 0) != 0);
   end
endmodule

//--- tb/testbench.sv
// self-checking bench for the vector logical unit
`timescale 1ns/100ps
`include "vlu_consts.svh"
module testbench;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic issue_valid = 1'b0;
   logic [6:0] issue_op = 7'h00;
   logic [2:0] issue_dst = 3'h0;
   logic [2:0] issue_src1 = 3'h0;
   logic [2:0] issue_src2 = 3'h0;
   logic [63:0] source_scalar_reg = 64'h0;
   logic [6:0] vec_length = 7'h00;
   logic regs_free = 1'b0;
   logic restart = 1'b0;
   logic jitter = 1'b0;
   logic hold_res = 1'b0;
   logic [63:0] pa = 64'h0;
   logic [63:0] pb = 64'h0;
   logic issue_ready, next_issue_pulse, src_release_pulse, dest_ready_pulse, unit_free_pulse;
   logic elem_valid, elem_ready, res_valid, res_ready;
   logic [2:0] dest_vector_reg, first_source_vector_reg, second_source_vector_reg;
   logic [63:0] first_source_elem, second_source_elem, res_data;
   logic [5:0] res_index;
   logic [6:0] taken_cnt;
   logic [63:0] exp_data[$];
   logic [5:0] exp_idx[$];
   logic [6:0] ops [6] = '{`VLU_OP_AND_SV, `VLU_OP_AND_VV, `VLU_OP_XOR_SV,
      `VLU_OP_XOR_VV, `VLU_OP_OR_SV, `VLU_OP_OR_VV};
   logic [6:0] lens [4] = '{7'h01, 7'h04, 7'h05, 7'h40};
   int failures = 0;
   int comparisons = 0;

   always #5 core_clk = ~core_clk;

   vlu_top vlu_top_i (.core_clk, .rst_n, .issue_valid, .issue_op, .issue_dst, .issue_src1,
      .issue_src2, .source_scalar_reg, .vec_length, .regs_free, .issue_ready, .next_issue_pulse,
      .src_release_pulse, .dest_ready_pulse, .unit_free_pulse, .dest_vector_reg,
      .first_source_vector_reg, .second_source_vector_reg, .elem_valid, .first_source_elem,
      .second_source_elem, .elem_ready, .res_valid, .res_data, .res_index, .res_ready);

   vlu_src_model vlu_src_model_i (.core_clk, .rst_n, .restart, .jitter, .hold_res, .pa, .pb,
      .elem_ready, .elem_valid, .first_source_elem, .second_source_elem, .res_ready, .taken_cnt);

   // ------------------------------------------------------------
   // comparison and verdict
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic give_verdict();
      if (failures == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // a spent wait bound counts as a mismatch and ends the run
   task automatic hang(input string what);
      check(what, 64'h0, 64'h1);
      give_verdict();
   endtask

   // oldest note against each accepted result
   always @(posedge core_clk) begin
      if (rst_n && res_valid === 1'b1 && res_ready === 1'b1) begin
         if (exp_data.size() == 0) begin
            check("extra result", 64'h1, 64'h0);
         end else begin
            check("res_data", res_data, exp_data.pop_front());
            check("res_index", 64'(res_index), 64'(exp_idx.pop_front()));
         end
      end
   end

   // ------------------------------------------------------------
   // one instruction: issue, note results, time the completions
   // ------------------------------------------------------------
   task automatic run_op(input logic [6:0] op, input logic [6:0] vl, input bit jit,
         input int blk, input int stall);
      logic [63:0] sc;
      logic [63:0] a;
      logic [63:0] b;
      logic [63:0] r;
      logic [6:0] cnt0;
      bit act;
      int k;
      int t_src;
      int t_dst;
      int t_unit;
      int xtra;
      act = vl != 7'h00 && op >= `VLU_OP_AND_SV && op <= `VLU_OP_OR_VV;
      xtra = (vl > 7'h04) ? int'(vl) - 4 : 0;
      t_src = 0;
      t_dst = 0;
      t_unit = 0;
      sc = {$urandom, $urandom};
      #1;
      jitter = jit;
      // rewind the source model only for streaming ops, so nulls stay back to back
      if (act) begin
         restart = 1'b1;
         pa = {$urandom, $urandom};
         pb = {$urandom, $urandom};
         @(posedge core_clk);
         #1;
         restart = 1'b0;
      end
      cnt0 = act ? vl : taken_cnt;
      issue_valid = 1'b1;
      issue_op = op;
      issue_dst = 3'($urandom);
      issue_src1 = 3'($urandom);
      issue_src2 = 3'($urandom);
      source_scalar_reg = sc;
      vec_length = vl;
      regs_free = blk == 0;
      repeat (blk) begin
         @(posedge core_clk);
         check("refused issue", 64'(next_issue_pulse), 64'h0);
      end
      if (blk > 0) begin
         #1;
         regs_free = 1'b1;
      end
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (issue_ready !== 1'b1 && k < 300);
      if (k >= 300) hang("issue wait");
      for (int n = 0; n < int'(vl) && act; n++) begin
         a = pa ^ {8{1'b0, 7'(n)}};
         b = pb + 64'(n);
         case (op)
            `VLU_OP_AND_SV: r = sc & b;
            `VLU_OP_AND_VV: r = a & b;
            `VLU_OP_XOR_SV: r = sc ^ b;
            `VLU_OP_XOR_VV: r = a ^ b;
            `VLU_OP_OR_SV: r = sc | b;
            default: r = a | b;
         endcase
         exp_data.push_back(r);
         exp_idx.push_back(6'(n));
      end
      #1;
      issue_valid = 1'b0;
      source_scalar_reg = ~sc; // the held copy must still be used
      hold_res = stall > 0;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
         if (k == 1) begin
            check("next issue", 64'(next_issue_pulse), 64'h1);
            check("busy", 64'(issue_ready), 64'(!act));
            if (act) begin
               check("dest reg", 64'(dest_vector_reg), 64'(issue_dst));
               check("src1 reg", 64'(first_source_vector_reg), 64'(issue_src1));
               check("src2 reg", 64'(second_source_vector_reg), 64'(issue_src2));
            end
         end
         if (src_release_pulse === 1'b1 && t_src == 0) t_src = k;
         if (dest_ready_pulse === 1'b1 && t_dst == 0) t_dst = k;
         if (unit_free_pulse === 1'b1 && t_unit == 0) begin
            t_unit = k;
            check("ready with free", 64'(issue_ready), 64'h1);
         end
         if (k == stall) begin
            check("intake stopped", 64'(taken_cnt < vl), 64'h1);
            #1;
            hold_res = 1'b0;
         end
      end while (act && (t_src == 0 || t_dst == 0 || t_unit == 0) && k < 1000);
      if (k >= 1000) hang("completion");
      if (act && !jit && stall == 0) begin
         check("src time", 64'(t_src), 64'(9 + xtra));
         check("dest time", 64'(t_dst), 64'(int'(vl) + 10));
         check("unit time", 64'(t_unit), 64'(11 + xtra));
      end else if (act) begin
         check("dest not early", 64'(t_dst >= int'(vl) + 10), 64'h1);
      end
      if (act) check("results left", 64'(exp_data.size()), 64'h0);
      check("elements taken", 64'(taken_cnt), 64'(cnt0));
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(32'hA383));
      repeat (6) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      repeat (2) @(posedge core_clk);
      // every operation at the length boundaries, full rate
      foreach (ops[i]) begin
         foreach (lens[j]) begin
            run_op(ops[i], lens[j], 1'b0, 0, 0);
         end
      end
      // reserved codes, zero length and an unused code run as no-ops
      run_op(`VLU_OP_RSV_A, 7'h08, 1'b0, 2, 0);
      run_op(`VLU_OP_RSV_B, 7'h08, 1'b0, 0, 0);
      run_op(`VLU_OP_AND_VV, 7'h00, 1'b0, 0, 0);
      run_op(7'h00, 7'h03, 1'b0, 0, 0);
      // busy registers hold an active issue back
      run_op(`VLU_OP_XOR_VV, 7'h06, 1'b0, 3, 0);
      // random traffic with gaps on both sides
      repeat (12) begin
         run_op(ops[$urandom_range(5, 0)], 7'($urandom_range(64, 1)), 1'b1, 0, 0);
      end
      // a long output stall fills the result buffer, then it drains
      run_op(`VLU_OP_OR_VV, 7'h14, 1'b0, 0, 30);
      give_verdict();
   end
endmodule
